// *** src/pmes_defines.svh ***
// Counts, widths, field positions, codes and reset values of the event selector
`ifndef PMES_DEFINES_SVH
`define PMES_DEFINES_SVH

`define PMES_NUM_CNT       6
`define PMES_SEL_W         6
`define PMES_CODE_W        8
`define PMES_CODE_MSB      7
`define PMES_DATA_W        32

`define PMES_RST_EVTYPE    8'h00
`define PMES_RST_SEL       6'h00
`define PMES_LAST_CNT      6'h05

`define PMES_EV_SWINC      8'h00
`define PMES_EV_IC_REFILL  8'h01
`define PMES_EV_ITLB       8'h02
`define PMES_EV_DC_ALLOC   8'h03
`define PMES_EV_DC_ACCESS  8'h04
`define PMES_EV_DTLB       8'h05
`define PMES_EV_LOAD       8'h06
`define PMES_EV_STORE      8'h07
`define PMES_EV_EXC_TAKEN  8'h09
`define PMES_EV_EXC_RET    8'h0A
`define PMES_EV_CTX_WR     8'h0B
`define PMES_EV_PC_WR      8'h0C
`define PMES_EV_IMM_BR     8'h0D
`define PMES_EV_UNALIGNED  8'h0F
`define PMES_EV_BR_MISP    8'h10
`define PMES_EV_CYCLES     8'h11
`define PMES_EV_BR_PRED    8'h12
`define PMES_EV_BC_HW      8'h40
`define PMES_EV_BC_SW      8'h41
`define PMES_EV_BC_BACKBR  8'h42
`define PMES_EV_COH_MISS   8'h50
`define PMES_EV_COH_HIT    8'h51
`define PMES_EV_IC_STALL   8'h60
`define PMES_EV_DC_STALL   8'h61
`define PMES_EV_WALK_STALL 8'h62
`define PMES_EV_STORE_EXCLUSIVE_OK   8'h63
`define PMES_EV_STORE_EXCLUSIVE_FAIL 8'h64
`define PMES_EV_DC_EVICT   8'h65
`define PMES_EV_NO_DISP    8'h66
`define PMES_EV_ISS_EMPTY  8'h67
`define PMES_EV_RENAME     8'h68
`define PMES_EV_PRED_RET   8'h6E
`define PMES_EV_MAIN_EXEC  8'h70
`define PMES_EV_ALU2_EXEC  8'h71

`endif

// *** src/pmes_event_select.sv ***
// Event code registers and event routing into six event counters
`timescale 1ns/1ps
`include "pmes_defines.svh"

module pmes_event_select (
  input  wire logic                 sys_clk,
  input  wire logic                 rstn,
  input  wire logic                 regWrite,
  input  wire logic                 regRead,
  input  wire pmes_pkg::pmes_reg_t  regSel,
  input  wire logic [31:0]          regWrData,
  input  wire pmes_pkg::pmes_events_t ev,
  input  wire logic                 ovfIrqReq,
  output logic [31:0]               regRdData,
  output logic                      regRdValid,
  output logic [5:0][1:0]           cntIncAmt,
  output logic                      monitorIrqPin
);

  pmes_pkg::pmes_state_t st_reg;
  pmes_pkg::pmes_state_t st_next;

  logic selValid;
  logic swincWr;

  // Amount a hardware event adds this cycle for a given code
  function automatic logic [1:0] evAmt(
    input logic [7:0]             code,
    input pmes_pkg::pmes_events_t e
  );
    logic hit;
    logic retForm;
    hit = 1'b0;
    retForm = e.retBxLr | e.retMovPcLr | e.retPopPc | e.retLdrPost;
    evAmt = 2'h0;
    case (code)
      `PMES_EV_SWINC:      hit = 1'b0;
      `PMES_EV_IC_REFILL:  hit = e.icRefill;
      `PMES_EV_ITLB:       hit = e.iTlbRefill;
      `PMES_EV_DC_ALLOC:   hit = e.dcAlloc;
      `PMES_EV_DC_ACCESS:  hit = e.dcAccess;
      `PMES_EV_DTLB:       hit = e.dTlbRefill & ~e.dTlbExcluded;
      `PMES_EV_LOAD:       hit = e.ldAccept;
      `PMES_EV_STORE:      hit = e.stAccept;
      `PMES_EV_EXC_TAKEN:  hit = e.excTaken;
      `PMES_EV_EXC_RET: begin
        hit = e.excRetLdmPc | e.excRetRfe | e.excRetDpPc;
      end
      `PMES_EV_CTX_WR:     hit = e.ctxIdWrite;
      `PMES_EV_PC_WR:      hit = e.swPcChange;
      `PMES_EV_IMM_BR:     hit = e.immBranch;
      `PMES_EV_UNALIGNED:  hit = e.unaligned;
      `PMES_EV_BR_MISP:    hit = e.brMispred;
      // Cycle event stays internal, there is no export path here
      `PMES_EV_CYCLES:     hit = ~e.coreWaitLp;
      `PMES_EV_BR_PRED:    hit = e.brPredictable;
      `PMES_EV_BC_HW:      hit = e.bcHw;
      `PMES_EV_BC_SW:      hit = e.bcSw;
      `PMES_EV_BC_BACKBR:  hit = e.bcBackBr;
      `PMES_EV_COH_MISS:   hit = e.cohMiss;
      `PMES_EV_COH_HIT:    hit = e.cohHit;
      `PMES_EV_IC_STALL:   hit = e.icStall;
      `PMES_EV_DC_STALL:   hit = e.dcStall & ~e.dcTlbPending;
      `PMES_EV_WALK_STALL: hit = e.walkStall;
      `PMES_EV_STORE_EXCLUSIVE_OK:   hit = e.strexPass;
      `PMES_EV_STORE_EXCLUSIVE_FAIL: hit = e.strexFail;
      `PMES_EV_DC_EVICT:   hit = e.dcEvict;
      `PMES_EV_NO_DISP:    hit = e.issueNoDisp;
      `PMES_EV_ISS_EMPTY:  hit = e.issueEmpty;
      `PMES_EV_PRED_RET: begin
        hit = retForm & e.retCondPass & ~e.retFromExc;
      end
      `PMES_EV_MAIN_EXEC:  hit = e.mainExec;
      `PMES_EV_ALU2_EXEC:  hit = e.alu2Exec;
      default:             hit = 1'b0;
    endcase
    if (code == `PMES_EV_RENAME) begin
      // Illegal pattern b11 is clipped to two
      if (e.renameCnt == 2'h3) begin
        evAmt = 2'h2;
      end else begin
        evAmt = e.renameCnt;
      end
    end else begin
      evAmt = {1'b0, hit};
    end
  endfunction

  // Select codes above five are unpredictable; treat them as no counter
  assign selValid = (st_reg.sel <= `PMES_LAST_CNT);
  assign swincWr  = regWrite && (regSel == pmes_pkg::PMES_REG_SWINC);

  always_comb begin
    st_next = st_reg;
    st_next.rdValid = 1'b0;
    st_next.irq = ovfIrqReq;
    if (regWrite) begin
      case (regSel)
        pmes_pkg::PMES_REG_SELECT: begin
          st_next.sel = regWrData[`PMES_SEL_W-1:0];
        end
        pmes_pkg::PMES_REG_EVTYPE: begin
          if (selValid) begin
            // Upper bits are dropped here, so they can never read back
            st_next.evType[st_reg.sel[2:0]] =
              regWrData[`PMES_CODE_MSB:0];
          end
        end
        default: begin
        end
      endcase
    end
    if (regRead) begin
      st_next.rdValid = 1'b1;
      st_next.rdData = 32'h0000_0000;
      case (regSel)
        pmes_pkg::PMES_REG_SELECT: begin
          st_next.rdData[`PMES_SEL_W-1:0] = st_reg.sel;
        end
        pmes_pkg::PMES_REG_EVTYPE: begin
          if (selValid) begin
            st_next.rdData[`PMES_CODE_MSB:0] =
              st_reg.evType[st_reg.sel[2:0]];
          end
        end
        default: begin
        end
      endcase
    end
    for (int i = 0; i < `PMES_NUM_CNT; i++) begin
      if (st_reg.evType[i] == `PMES_EV_SWINC) begin
        // Increment register only acts on counters set to code zero
        st_next.incAmt[i] = {1'b0, swincWr & regWrData[i]};
      end else begin
        st_next.incAmt[i] = evAmt(st_reg.evType[i], ev);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_reg.evType  <= {`PMES_NUM_CNT{`PMES_RST_EVTYPE}};
      st_reg.sel     <= `PMES_RST_SEL;
      st_reg.incAmt  <= '0;
      st_reg.rdData  <= 32'h0000_0000;
      st_reg.rdValid <= 1'b0;
      st_reg.irq     <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign regRdData     = st_reg.rdData;
  assign regRdValid    = st_reg.rdValid;
  assign cntIncAmt     = st_reg.incAmt;
  assign monitorIrqPin = st_reg.irq;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  logic evtRd;
  logic swinc0;
  assign evtRd  = regRead && (regSel == pmes_pkg::PMES_REG_EVTYPE);
  assign swinc0 = swincWr && regWrData[0];

  evtype_read_a: assert property (
    evtRd |=> regRdValid && (regRdData[31:8] == 24'h00_0000))
    else $error("event type upper bits not zero");

  evtype_store_a: assert property (
    regWrite && regSel == pmes_pkg::PMES_REG_EVTYPE && selValid
    ##1 !regWrite ##1 evtRd && !regWrite
    |=> regRdData[7:0] == $past(regWrData[7:0], 3))
    else $error("event type write not read back");

  swinc_idle_a: assert property (
    st_reg.evType[0] == `PMES_EV_SWINC && !swinc0
    |=> cntIncAmt[0] == 2'h0)
    else $error("code zero counted without software write");

  swinc_bump_a: assert property (
    st_reg.evType[0] == `PMES_EV_SWINC && swinc0
    |=> cntIncAmt[0] == 2'h1)
    else $error("software increment lost");

  rsvd_code_a: assert property (
    st_reg.evType[1] inside {8'h08, 8'h0E, 8'h13, 8'h3F, 8'hFF}
    |=> cntIncAmt[1] == 2'h0)
    else $error("reserved code counted");

  cycle_count_a: assert property (
    st_reg.evType[1] == `PMES_EV_CYCLES
    |=> cntIncAmt[1] == {1'b0, !$past(ev.coreWaitLp)})
    else $error("cycle event wrong");

  rename_width_a: assert property (
    st_reg.evType[1] == `PMES_EV_RENAME && ev.renameCnt != 2'h3
    |=> cntIncAmt[1] == $past(ev.renameCnt))
    else $error("rename amount wrong");

  store_exclusive_pass_a: assert property (
    st_reg.evType[1] == `PMES_EV_STORE_EXCLUSIVE_OK
    |=> cntIncAmt[1] == {1'b0, $past(ev.strexPass)})
    else $error("store exclusive pass miscounted");

  ret_exc_a: assert property (
    st_reg.evType[1] == `PMES_EV_PRED_RET && ev.retFromExc
    |=> cntIncAmt[1] == 2'h0)
    else $error("exception return counted as procedure return");

  dtlb_excl_a: assert property (
    st_reg.evType[1] == `PMES_EV_DTLB && ev.dTlbExcluded
    |=> cntIncAmt[1] == 2'h0)
    else $error("excluded data TLB miss counted");

  irq_pin_a: assert property (
    ovfIrqReq |=> monitorIrqPin)
    else $error("interrupt pin not following request");

  irq_drop_a: assert property (
    !ovfIrqReq |=> !monitorIrqPin)
    else $error("interrupt pin high without request");

  rename_clip_a: assert property (
    st_reg.evType[1] == `PMES_EV_RENAME && ev.renameCnt == 2'h3
    |=> cntIncAmt[1] == 2'h2)
    else $error("illegal rename pattern not clipped");

  icache_refill_a: assert property (
    st_reg.evType[1] == `PMES_EV_IC_REFILL
    |=> cntIncAmt[1] == {1'b0, $past(ev.icRefill)})
    else $error("instruction cache refill miscounted");

  itlb_refill_a: assert property (
    st_reg.evType[1] == `PMES_EV_ITLB
    |=> cntIncAmt[1] == {1'b0, $past(ev.iTlbRefill)})
    else $error("instruction TLB refill miscounted");

  dc_alloc_a: assert property (
    st_reg.evType[1] == `PMES_EV_DC_ALLOC
    |=> cntIncAmt[1] == {1'b0, $past(ev.dcAlloc)})
    else $error("data cache allocation miscounted");

  dc_access_a: assert property (
    st_reg.evType[1] == `PMES_EV_DC_ACCESS
    |=> cntIncAmt[1] == {1'b0, $past(ev.dcAccess)})
    else $error("data cache access miscounted");

  load_accept_a: assert property (
    st_reg.evType[1] == `PMES_EV_LOAD
    |=> cntIncAmt[1] == {1'b0, $past(ev.ldAccept)})
    else $error("accepted load miscounted");

  store_accept_a: assert property (
    st_reg.evType[1] == `PMES_EV_STORE
    |=> cntIncAmt[1] == {1'b0, $past(ev.stAccept)})
    else $error("accepted store miscounted");

  exc_taken_a: assert property (
    st_reg.evType[1] == `PMES_EV_EXC_TAKEN
    |=> cntIncAmt[1] == {1'b0, $past(ev.excTaken)})
    else $error("taken exception miscounted");

  exc_return_a: assert property (
    st_reg.evType[1] == `PMES_EV_EXC_RET && ev.excRetDpPc
    |=> cntIncAmt[1] == 2'h1)
    else $error("exception return not counted");

  ctx_write_a: assert property (
    st_reg.evType[1] == `PMES_EV_CTX_WR
    |=> cntIncAmt[1] == {1'b0, $past(ev.ctxIdWrite)})
    else $error("context identifier write miscounted");

  pc_change_a: assert property (
    st_reg.evType[1] == `PMES_EV_PC_WR
    |=> cntIncAmt[1] == {1'b0, $past(ev.swPcChange)})
    else $error("software PC change miscounted");

  imm_branch_a: assert property (
    st_reg.evType[1] == `PMES_EV_IMM_BR
    |=> cntIncAmt[1] == {1'b0, $past(ev.immBranch)})
    else $error("immediate branch miscounted");

  unaligned_acc_a: assert property (
    st_reg.evType[1] == `PMES_EV_UNALIGNED
    |=> cntIncAmt[1] == {1'b0, $past(ev.unaligned)})
    else $error("unaligned access miscounted");

  br_mispred_a: assert property (
    st_reg.evType[1] == `PMES_EV_BR_MISP
    |=> cntIncAmt[1] == {1'b0, $past(ev.brMispred)})
    else $error("mispredicted branch miscounted");

  bc_decode_a: assert property (
    st_reg.evType[1] == `PMES_EV_BC_HW
    |=> cntIncAmt[1] == {1'b0, $past(ev.bcHw)})
    else $error("hardware bytecode miscounted");

  coh_miss_a: assert property (
    st_reg.evType[1] == `PMES_EV_COH_MISS
    |=> cntIncAmt[1] == {1'b0, $past(ev.cohMiss)})
    else $error("coherent linefill miss miscounted");

  dc_stall_a: assert property (
    st_reg.evType[1] == `PMES_EV_DC_STALL && ev.dcTlbPending
    |=> cntIncAmt[1] == 2'h0)
    else $error("data stall counted with TLB request pending");

  issue_empty_a: assert property (
    st_reg.evType[1] == `PMES_EV_ISS_EMPTY
    |=> cntIncAmt[1] == {1'b0, $past(ev.issueEmpty)})
    else $error("empty issue cycle miscounted");

  main_exec_a: assert property (
    st_reg.evType[1] == `PMES_EV_MAIN_EXEC
    |=> cntIncAmt[1] == {1'b0, $past(ev.mainExec)})
    else $error("main pipeline instruction miscounted");

  swinc_cov: cover property (
    st_reg.evType[0] == `PMES_EV_SWINC && swinc0 ##1 cntIncAmt[0] != 0);
  rename_cov: cover property (cntIncAmt[1] == 2'h2);
  irq_cov: cover property (!monitorIrqPin ##1 monitorIrqPin);
  read_cov: cover property (evtRd ##1 regRdData[7:0] != 8'h00);

endmodule

// *** src/pmes_pkg.sv ***
// Types shared by the event selector and its bench
package pmes_pkg;

  typedef enum logic [1:0] {
    PMES_REG_SELECT,
    PMES_REG_EVTYPE,
    PMES_REG_SWINC,
    PMES_REG_NONE
  } pmes_reg_t;

  typedef struct packed {
    logic       icRefill;
    logic       iTlbRefill;
    logic       dcAlloc;
    logic       dcAccess;
    logic       dTlbRefill;
    logic       dTlbExcluded;
    logic       ldAccept;
    logic       stAccept;
    logic       excTaken;
    logic       excRetLdmPc;
    logic       excRetRfe;
    logic       excRetDpPc;
    logic       ctxIdWrite;
    logic       swPcChange;
    logic       immBranch;
    logic       unaligned;
    logic       brMispred;
    logic       coreWaitLp;
    logic       brPredictable;
    logic       bcHw;
    logic       bcSw;
    logic       bcBackBr;
    logic       cohMiss;
    logic       cohHit;
    logic       icStall;
    logic       dcStall;
    logic       dcTlbPending;
    logic       walkStall;
    logic       strexPass;
    logic       strexFail;
    logic       dcEvict;
    logic       issueNoDisp;
    logic       issueEmpty;
    logic [1:0] renameCnt;
    logic       retBxLr;
    logic       retMovPcLr;
    logic       retPopPc;
    logic       retLdrPost;
    logic       retCondPass;
    logic       retFromExc;
    logic       mainExec;
    logic       alu2Exec;
  } pmes_events_t;

  typedef struct packed {
    logic [5:0][7:0] evType;
    logic [5:0]      sel;
    logic [5:0][1:0] incAmt;
    logic [31:0]     rdData;
    logic            rdValid;
    logic            irq;
  } pmes_state_t;

endpackage

// *** tb/tb_top.sv ***
// Self-checking bench for the event selector
`timescale 1ns/1ps
module tb_top;
  logic                   sys_clk;
  logic                   rstn;
  logic                   regWrite;
  logic                   regRead;
  pmes_pkg::pmes_reg_t    regSel;
  logic [31:0]            regWrData;
  pmes_pkg::pmes_events_t ev;
  pmes_pkg::pmes_events_t x;
  logic                   ovfIrqReq;
  logic [31:0]            regRdData;
  logic                   regRdValid;
  logic [5:0][1:0]        cntIncAmt;
  logic                   monitorIrqPin;
  int                     err_count;
  int                     comparisons;
  logic [7:0]             cd [32] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
    8'h06, 8'h07, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0F, 8'h10, 8'h12,
    8'h40, 8'h41, 8'h42, 8'h50, 8'h51, 8'h60, 8'h61, 8'h62, 8'h63, 8'h64,
    8'h65, 8'h66, 8'h67, 8'h68, 8'h6E, 8'h70, 8'h71};
  logic [7:0]             rsv [6] = '{8'h08, 8'h0E, 8'h13, 8'h3F, 8'h72,
    8'hFF};

  pmes_event_select u_dut (
    .sys_clk       (sys_clk),
    .rstn          (rstn),
    .regWrite      (regWrite),
    .regRead       (regRead),
    .regSel        (regSel),
    .regWrData     (regWrData),
    .ev            (ev),
    .ovfIrqReq     (ovfIrqReq),
    .regRdData     (regRdData),
    .regRdValid    (regRdValid),
    .cntIncAmt     (cntIncAmt),
    .monitorIrqPin (monitorIrqPin)
  );

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic give_verdict;
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Idle cycle after a write so the new code is in force
  task automatic wr(input pmes_pkg::pmes_reg_t r, input logic [31:0] d);
    regWrite = 1'b1;
    regSel = r;
    regWrData = d;
    @(negedge sys_clk);
    regWrite = 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic rd(input pmes_pkg::pmes_reg_t r, input logic [31:0] exp);
    regRead = 1'b1;
    regSel = r;
    @(negedge sys_clk);
    regRead = 1'b0;
    chk("regRdValid", 32'h1, {31'h0, regRdValid});
    chk("regRdData", exp, regRdData);
    // Idle edge so back-to-back reads always retoggle the strobe
    @(negedge sys_clk);
  endtask

  // Whole vector compared so crosstalk into other counters shows
  task automatic evt(input logic [7:0] code,
                     input pmes_pkg::pmes_events_t e, input logic [1:0] n);
    logic [5:0][1:0] v;
    v = '0;
    v[1] = n;
    wr(pmes_pkg::PMES_REG_EVTYPE, {24'h0, code});
    ev = e;
    @(negedge sys_clk);
    ev = '0;
    chk("cntIncAmt", {20'h0, v}, {20'h0, cntIncAmt});
  endtask

  task automatic swinc(input logic [31:0] d, input logic [11:0] v);
    regWrite = 1'b1;
    regSel = pmes_pkg::PMES_REG_SWINC;
    regWrData = d;
    @(negedge sys_clk);
    regWrite = 1'b0;
    chk("swincAmt", {20'h0, v}, {20'h0, cntIncAmt});
    @(negedge sys_clk);
    chk("swincIdle", 32'h0, {20'h0, cntIncAmt});
  endtask

  function automatic pmes_pkg::pmes_events_t mkev(input logic [7:0] c);
    pmes_pkg::pmes_events_t e;
    e = '0;
    case (c)
      8'h01: e.icRefill = 1'b1;
      8'h02: e.iTlbRefill = 1'b1;
      8'h03: e.dcAlloc = 1'b1;
      8'h04: e.dcAccess = 1'b1;
      8'h05: e.dTlbRefill = 1'b1;
      8'h06: e.ldAccept = 1'b1;
      8'h07: e.stAccept = 1'b1;
      8'h09: e.excTaken = 1'b1;
      8'h0A: e.excRetRfe = 1'b1;
      8'h0B: e.ctxIdWrite = 1'b1;
      8'h0C: e.swPcChange = 1'b1;
      8'h0D: e.immBranch = 1'b1;
      8'h0F: e.unaligned = 1'b1;
      8'h10: e.brMispred = 1'b1;
      8'h12: e.brPredictable = 1'b1;
      8'h40: e.bcHw = 1'b1;
      8'h41: e.bcSw = 1'b1;
      8'h42: e.bcBackBr = 1'b1;
      8'h50: e.cohMiss = 1'b1;
      8'h51: e.cohHit = 1'b1;
      8'h60: e.icStall = 1'b1;
      8'h61: e.dcStall = 1'b1;
      8'h62: e.walkStall = 1'b1;
      8'h63: e.strexPass = 1'b1;
      8'h64: e.strexFail = 1'b1;
      8'h65: e.dcEvict = 1'b1;
      8'h66: e.issueNoDisp = 1'b1;
      8'h67: e.issueEmpty = 1'b1;
      8'h68: e.renameCnt = 2'h1;
      8'h6E: e.retBxLr = 1'b1;
      8'h70: e.mainExec = 1'b1;
      8'h71: e.alu2Exec = 1'b1;
      default: e = '0;
    endcase
    if (c == 8'h6E) begin
      e.retCondPass = 1'b1;
    end
    return e;
  endfunction

  task automatic run(input int lo, input int hi);
    for (int i = lo; i <= hi; i++) begin
      evt(cd[i], mkev(cd[i]), 2'h1);
    end
  endtask

  // Fixed latencies everywhere; this only catches a stuck run
  initial begin
    repeat (100000) @(posedge sys_clk);
    err_count++;
    give_verdict();
  end

  initial begin
    err_count = 0;
    comparisons = 0;
    rstn = 1'b0;
    regWrite = 1'b0;
    regRead = 1'b0;
    regSel = pmes_pkg::PMES_REG_NONE;
    regWrData = 32'h0;
    ev = '0;
    ovfIrqReq = 1'b0;
    repeat (10) @(negedge sys_clk);
    rstn = 1'b1;
    chk("rstInc", 32'h0, {20'h0, cntIncAmt});
    @(negedge sys_clk);
    rd(pmes_pkg::PMES_REG_EVTYPE, 32'h0);
    rd(pmes_pkg::PMES_REG_SELECT, 32'h0);
    wr(pmes_pkg::PMES_REG_SELECT, 32'h1);
    run(0, 6);
    run(7, 12);
    run(13, 19);
    run(20, 27);
    run(28, 31);
    evt(8'h11, '0, 2'h1);
    x = '0;
    x.coreWaitLp = 1'b1;
    evt(8'h11, x, 2'h0);
    x = '0;
    x.excRetLdmPc = 1'b1;
    evt(8'h0A, x, 2'h1);
    x = mkev(8'h05);
    x.dTlbExcluded = 1'b1;
    evt(8'h05, x, 2'h0);
    x = mkev(8'h61);
    x.dcTlbPending = 1'b1;
    evt(8'h61, x, 2'h0);
    x = mkev(8'h6E);
    x.retFromExc = 1'b1;
    evt(8'h6E, x, 2'h0);
    x = mkev(8'h6E);
    x.retCondPass = 1'b0;
    evt(8'h6E, x, 2'h0);
    for (int k = 0; k < 3; k++) begin
      x = '0;
      x.renameCnt = k[1:0];
      evt(8'h68, x, k[1:0]);
    end
    x = '0;
    x.renameCnt = 2'h3;
    evt(8'h68, x, 2'h2);
    evt(8'h00, '1, 2'h0);
    foreach (rsv[i]) evt(rsv[i], '1, 2'h0);
    wr(pmes_pkg::PMES_REG_EVTYPE, 32'hFFFF_FF68);
    rd(pmes_pkg::PMES_REG_EVTYPE, 32'h0000_0068);
    wr(pmes_pkg::PMES_REG_SELECT, 32'h5);
    wr(pmes_pkg::PMES_REG_EVTYPE, 32'h42);
    rd(pmes_pkg::PMES_REG_EVTYPE, 32'h42);
    wr(pmes_pkg::PMES_REG_SELECT, 32'h1);
    rd(pmes_pkg::PMES_REG_EVTYPE, 32'h68);
    wr(pmes_pkg::PMES_REG_SELECT, 32'h6);
    wr(pmes_pkg::PMES_REG_EVTYPE, 32'h11);
    rd(pmes_pkg::PMES_REG_EVTYPE, 32'h0);
    wr(pmes_pkg::PMES_REG_SELECT, 32'hFFFF_FFE1);
    rd(pmes_pkg::PMES_REG_SELECT, 32'h0000_0021);
    rd(pmes_pkg::PMES_REG_EVTYPE, 32'h0);
    wr(pmes_pkg::PMES_REG_SELECT, 32'h5);
    rd(pmes_pkg::PMES_REG_EVTYPE, 32'h42);
    swinc(32'h3F, 12'h151);
    swinc(32'h0, 12'h000);
    rd(pmes_pkg::PMES_REG_SWINC, 32'h0);
    chk("rdValidDrop", 32'h0, {31'h0, regRdValid});
    ovfIrqReq = 1'b1;
    @(negedge sys_clk);
    ovfIrqReq = 1'b0;
    chk("irqHigh", 32'h1, {31'h0, monitorIrqPin});
    @(negedge sys_clk);
    chk("irqLow", 32'h0, {31'h0, monitorIrqPin});
    give_verdict();
  end
endmodule
